// ==== hdl/mcp_pkg.sv ====
// Purpose: Shared constants for the motor current power-down controller
// Assumes: Register offsets are word indices on the device register port
// Notes: Reset values and field positions are defined here

package mcp_pkg;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [7:0] MCP_RUN_HOLD_IDX = 8'h12;
  localparam logic [7:0] MCP_PD_WAIT_IDX = 8'h13;
  localparam logic [7:0] MCP_INTERVAL_IDX = 8'h14;

  // ****************************************
  // Field positions of run_hold_current and the power-down wait
  // ****************************************
  localparam int MCP_RUN_DLY_LSB = 24;
  localparam int MCP_HOLD_DLY_LSB = 16;
  localparam int MCP_RUN_CUR_LSB = 8;
  localparam int MCP_HOLD_CUR_LSB = 0;
  localparam int MCP_PD_WAIT_LSB = 0;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [3:0] MCP_RUN_DLY_RST = 4'h4;
  localparam logic [3:0] MCP_HOLD_DLY_RST = 4'h1;
  localparam logic [4:0] MCP_RUN_CUR_RST = 5'h1f;
  localparam logic [4:0] MCP_HOLD_CUR_RST = 5'h08;
  localparam logic [7:0] MCP_PD_WAIT_RST = 8'h0a;
  localparam logic [19:0] MCP_INTERVAL_RST = 20'h00000;

  // ****************************************
  // Cycle counts and hysteresis shift
  // ****************************************
  localparam int MCP_RUN_UNIT_CYC = 512;
  localparam int MCP_HOLD_UNIT_CYC = 262144;
  localparam logic [19:0] MCP_INTERVAL_MAX = 20'hfffff;
  localparam int MCP_HYST_SHIFT = 4;

  // Current ramp states
  typedef enum logic [2:0] {
    MCP_ST_HOLD,
    MCP_ST_UP,
    MCP_ST_RUN,
    MCP_ST_WAIT,
    MCP_ST_DOWN
  } mcp_state_e;

endpackage : mcp_pkg

// ==== hdl/mcp_hyst_if.sv ====
// Purpose: Carries interval, threshold and compare result between modules
// Assumes: Single clock domain
// Notes: The comparator owns the result, the controller owns the inputs

`timescale 1ns/1ps
`default_nettype none

interface mcp_hyst_if;
  logic [19:0] interval;
  logic [19:0] threshold;
  logic below;

  modport ctrl (output interval, output threshold, input below);
  modport cmp (input interval, input threshold, output below);
endinterface : mcp_hyst_if

`default_nettype wire

// ==== hdl/mcp_hyst_cmp.sv ====
// Purpose: Interval against threshold compare with a 1/16 hysteresis band
// Assumes: Interval and threshold are in clock periods
// Notes: Below sets under the threshold, clears at threshold plus 1/16

`timescale 1ns/1ps
`default_nettype none

module mcp_hyst_cmp
  import mcp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Compare channel
  mcp_hyst_if.cmp hyst
);

  logic below_reg;
  logic below_next;
  wire logic [20:0] release_lvl;
  wire logic set_hit;
  wire logic clr_hit;

  // Band edges; 21 bits so a large threshold cannot wrap the upper edge
  assign release_lvl = {1'b0, hyst.threshold} + {5'h00, hyst.threshold[19:MCP_HYST_SHIFT]};
  assign set_hit = hyst.interval < hyst.threshold;
  assign clr_hit = {1'b0, hyst.interval} >= release_lvl;
  assign below_next = set_hit ? 1'b1 : (clr_hit ? 1'b0 : below_reg);
  assign hyst.below = below_reg;

  // Result flop; in-band values keep the last decision to reject jitter
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      below_reg <= 1'b0;
    end else begin
      below_reg <= below_next;
    end
  end

  hyst_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    set_hit |=> below_reg)
    else $error("below flag not set under threshold");

  hyst_clr_a: assert property (@(posedge clk_sys) disable iff (srst)
    (!set_hit && clr_hit) |=> !below_reg)
    else $error("below flag not cleared above band");

  hyst_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    (!set_hit && !clr_hit) |=> below_reg == $past(below_reg))
    else $error("below flag moved inside band");

endmodule : mcp_hyst_cmp

`default_nettype wire

// ==== hdl/mcp_ctrl.sv ====
// Purpose: Run and standstill current selection with ramps and power-down wait
// Assumes: Register port is synchronous; step_pulse marks one 1/256 microstep
// Notes: Long unit counts are parameters so a simulation can shorten them

`timescale 1ns/1ps
`default_nettype none

module mcp_ctrl
  import mcp_pkg::*;
#(
  parameter int RUN_UNIT_CYC = MCP_RUN_UNIT_CYC,
  parameter int HOLD_UNIT_CYC = MCP_HOLD_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_we,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_re,
  output logic [31:0] reg_rdata_reg,
  // Motion status
  input wire logic motion_req,
  input wire logic standstill,
  input wire logic step_pulse,
  input wire logic pwm_voltage_mode,
  input wire logic freewheel_sel,
  input wire logic [19:0] velocity_threshold,
  // Chopper and indexer side
  output logic [4:0] current_scale_reg,
  output logic run_current_reached_reg,
  output logic freewheel_reg,
  output logic coil_short_reg,
  output logic below_threshold
);

  // ****************************************
  // Registers
  // ****************************************
  logic [3:0] run_ramp_step_delay_reg;
  logic [3:0] hold_ramp_step_delay_reg;
  logic [4:0] run_current_scale_reg;
  logic [4:0] standstill_current_scale_reg;
  logic [7:0] standstill_powerdown_wait_reg;
  logic [19:0] microstep_interval_reg;
  logic [19:0] step_cnt_reg;
  logic [31:0] tick_cnt_reg;
  logic [7:0] unit_cnt_reg;
  mcp_state_e state_reg;
  mcp_state_e state_next;

  mcp_hyst_if hyst ();

  // ****************************************
  // Register decode
  // ****************************************
  wire logic wr_run_hold = reg_we && (reg_addr == MCP_RUN_HOLD_IDX);
  wire logic wr_pd_wait = reg_we && (reg_addr == MCP_PD_WAIT_IDX);
  wire logic [31:0] run_hold_word = {4'h0, run_ramp_step_delay_reg, 4'h0,
    hold_ramp_step_delay_reg, 3'h0, run_current_scale_reg, 3'h0,
    standstill_current_scale_reg};
  wire logic [31:0] rd_word =
    (reg_addr == MCP_RUN_HOLD_IDX) ? run_hold_word :
    (reg_addr == MCP_PD_WAIT_IDX) ? {24'h000000, standstill_powerdown_wait_reg} :
    (reg_addr == MCP_INTERVAL_IDX) ? {12'h000, microstep_interval_reg} :
    32'h00000000;

  // Configuration writes; the interval register ignores writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      run_ramp_step_delay_reg <= MCP_RUN_DLY_RST;
      hold_ramp_step_delay_reg <= MCP_HOLD_DLY_RST;
      run_current_scale_reg <= MCP_RUN_CUR_RST;
      standstill_current_scale_reg <= MCP_HOLD_CUR_RST;
      standstill_powerdown_wait_reg <= MCP_PD_WAIT_RST;
    end else begin
      if (wr_run_hold) begin
        run_ramp_step_delay_reg <= reg_wdata[MCP_RUN_DLY_LSB +: 4];
        hold_ramp_step_delay_reg <= reg_wdata[MCP_HOLD_DLY_LSB +: 4];
        run_current_scale_reg <= reg_wdata[MCP_RUN_CUR_LSB +: 5];
        standstill_current_scale_reg <= reg_wdata[MCP_HOLD_CUR_LSB +: 5];
      end
      if (wr_pd_wait) begin
        standstill_powerdown_wait_reg <= reg_wdata[MCP_PD_WAIT_LSB +: 8];
      end
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata_reg <= 32'h00000000;
    end else if (reg_re) begin
      reg_rdata_reg <= rd_word;
    end
  end

  // ****************************************
  // Microstep interval
  // ****************************************
  wire logic step_sat = (step_cnt_reg == MCP_INTERVAL_MAX);
  wire logic [19:0] step_cnt_next = step_pulse ? 20'h00001 :
    (step_sat ? MCP_INTERVAL_MAX : step_cnt_reg + 20'h00001);
  wire logic [19:0] interval_next = (standstill || step_sat) ? MCP_INTERVAL_MAX :
    (step_pulse ? step_cnt_reg : microstep_interval_reg);

  // Counter starts saturated so the first step after reset reads as max
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      step_cnt_reg <= MCP_INTERVAL_MAX;
      microstep_interval_reg <= MCP_INTERVAL_RST;
    end else begin
      step_cnt_reg <= step_cnt_next;
      microstep_interval_reg <= interval_next;
    end
  end

  // Threshold compare shares the interval through the interface
  assign hyst.interval = microstep_interval_reg;
  assign hyst.threshold = velocity_threshold;

  mcp_hyst_cmp u_hyst (
    .clk_sys(clk_sys),
    .srst(srst),
    .hyst(hyst.cmp)
  );

  assign below_threshold = hyst.below;

  // ****************************************
  // Current ramp control
  // ****************************************
  wire logic [31:0] run_limit = 32'(run_ramp_step_delay_reg) * 32'(RUN_UNIT_CYC);
  wire logic [31:0] hold_limit = 32'(hold_ramp_step_delay_reg) * 32'(HOLD_UNIT_CYC);
  wire logic [31:0] hold_unit = 32'(HOLD_UNIT_CYC);
  wire logic ramping = (state_reg == MCP_ST_UP) || (state_reg == MCP_ST_DOWN);
  wire logic [4:0] target = (state_reg == MCP_ST_UP) ? run_current_scale_reg :
    standstill_current_scale_reg;
  wire logic [3:0] step_dly = (state_reg == MCP_ST_UP) ? run_ramp_step_delay_reg :
    hold_ramp_step_delay_reg;
  wire logic [31:0] step_limit = (state_reg == MCP_ST_UP) ? run_limit : hold_limit;
  wire logic step_due = (step_dly == 4'h0) || (tick_cnt_reg >= step_limit - 32'h1);
  wire logic unit_due = (tick_cnt_reg == hold_unit - 32'h1);
  wire logic wait_done = (unit_cnt_reg >= standstill_powerdown_wait_reg);
  wire logic at_target = (current_scale_reg == target);
  // One 1/32 step toward the target, or straight there with zero delay
  wire logic [4:0] stepped = (step_dly == 4'h0) ? target :
    ((current_scale_reg < target) ? current_scale_reg + 5'h01 :
    current_scale_reg - 5'h01);

  // Next state; motion always wins over power-down
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MCP_ST_HOLD: begin
        if (motion_req) begin
          state_next = MCP_ST_UP;
        end else if (current_scale_reg != standstill_current_scale_reg) begin
          state_next = MCP_ST_DOWN;
        end
      end
      MCP_ST_UP: begin
        if (at_target) begin
          state_next = MCP_ST_RUN;
        end
      end
      MCP_ST_RUN: begin
        if (current_scale_reg != run_current_scale_reg) begin
          state_next = MCP_ST_UP;
        end else if (!motion_req) begin
          state_next = MCP_ST_WAIT;
        end
      end
      MCP_ST_WAIT: begin
        if (motion_req) begin
          state_next = MCP_ST_UP;
        end else if (standstill && wait_done) begin
          state_next = MCP_ST_DOWN;
        end
      end
      MCP_ST_DOWN: begin
        if (motion_req) begin
          state_next = MCP_ST_UP;
        end else if (at_target) begin
          state_next = MCP_ST_HOLD;
        end
      end
    endcase
  end

  // State, step timer and power-down unit counter
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= MCP_ST_HOLD;
      tick_cnt_reg <= 32'h00000000;
      unit_cnt_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        tick_cnt_reg <= 32'h00000000;
        unit_cnt_reg <= 8'h00;
      end else if (state_reg == MCP_ST_WAIT) begin
        // Standstill dropping restarts the whole wait
        if (!standstill) begin
          tick_cnt_reg <= 32'h00000000;
          unit_cnt_reg <= 8'h00;
        end else if (unit_due) begin
          tick_cnt_reg <= 32'h00000000;
          unit_cnt_reg <= unit_cnt_reg + 8'h01;
        end else begin
          tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
      end else if (ramping && !at_target) begin
        tick_cnt_reg <= step_due ? 32'h00000000 : tick_cnt_reg + 32'h1;
      end
    end
  end

  // Effective scale; reset sits at the reset standstill level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      current_scale_reg <= MCP_HOLD_CUR_RST;
      run_current_reached_reg <= 1'b0;
      freewheel_reg <= 1'b0;
      coil_short_reg <= 1'b0;
    end else begin
      if (ramping && !at_target && step_due && state_next == state_reg) begin
        current_scale_reg <= stepped;
      end
      run_current_reached_reg <= (state_next == MCP_ST_RUN);
      // Passive standstill only once the hold level is really reached
      freewheel_reg <= pwm_voltage_mode && (standstill_current_scale_reg == 5'h00) &&
        (state_next == MCP_ST_HOLD) && freewheel_sel;
      coil_short_reg <= pwm_voltage_mode && (standstill_current_scale_reg == 5'h00) &&
        (state_next == MCP_ST_HOLD) && !freewheel_sel;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  instant_up_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_reg == MCP_ST_UP && run_ramp_step_delay_reg == 4'h0 && !at_target)
      |=> current_scale_reg == $past(run_current_scale_reg))
    else $error("zero run delay did not jump to run current");

  up_step_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_reg == MCP_ST_UP && run_ramp_step_delay_reg != 4'h0 && !$stable(current_scale_reg))
      |-> (current_scale_reg == $past(current_scale_reg) + 5'h01 ||
        current_scale_reg == $past(current_scale_reg) - 5'h01))
    else $error("ramp moved by more than one step");

  run_gap_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_reg == MCP_ST_UP && run_ramp_step_delay_reg != 4'h0 && !at_target &&
      tick_cnt_reg < run_limit - 32'h1)
      |=> $stable(current_scale_reg))
    else $error("run ramp step came too early");

  wait_expired_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_reg == MCP_ST_WAIT ##1 state_reg == MCP_ST_DOWN)
      |-> $past(unit_cnt_reg) >= $past(standstill_powerdown_wait_reg) && $past(standstill))
    else $error("power-down began before the wait expired");

  wait_restart_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_reg == MCP_ST_WAIT && !standstill && !motion_req) |=> unit_cnt_reg == 8'h00)
    else $error("wait count survived loss of standstill");

  instant_down_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_reg == MCP_ST_DOWN && hold_ramp_step_delay_reg == 4'h0 && !at_target && !motion_req)
      |=> current_scale_reg == $past(standstill_current_scale_reg))
    else $error("zero hold delay did not jump to hold current");

  pd_reset_a: assert property (@(posedge clk_sys)
    $past(srst) |-> standstill_powerdown_wait_reg == 8'h0a && microstep_interval_reg == 20'h0)
    else $error("wrong value after reset");

  interval_sat_a: assert property (@(posedge clk_sys) disable iff (srst)
    standstill |=> microstep_interval_reg == 20'hfffff)
    else $error("interval not saturated at standstill");

  interval_meas_a: assert property (@(posedge clk_sys) disable iff (srst)
    (step_pulse && !standstill ##1 !step_pulse && !standstill [*3] ##1 step_pulse && !standstill)
      |=> microstep_interval_reg == 20'h00004)
    else $error("interval measurement wrong");

  passive_a: assert property (@(posedge clk_sys) disable iff (srst)
    (freewheel_reg || coil_short_reg) |-> state_reg == MCP_ST_HOLD &&
      !(freewheel_reg && coil_short_reg))
    else $error("passive standstill outside hold");

endmodule : mcp_ctrl

`default_nettype wire

// ==== dv/mcp_indexer_model.sv ====
// Purpose: Indexer stand-in that issues microstep pulses and standstill
// Assumes: One clock; pulses are spaced by the requested period
// Notes: Pulses stop and standstill rises as soon as run_en falls

`timescale 1ns/1ps
`default_nettype none

module mcp_indexer_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Bench control
  input wire logic run_en,
  input wire logic [19:0] period,
  // Toward the controller
  output logic step_pulse,
  output logic standstill
);
  logic [19:0] cnt_reg;

  // Restarting the count on each pulse keeps the spacing exact
  always_ff @(posedge clk_sys) begin
    if (srst || !run_en) begin
      cnt_reg <= 20'h00000;
      step_pulse <= 1'b0;
    end else if (cnt_reg >= period - 20'h00001) begin
      cnt_reg <= 20'h00000;
      step_pulse <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 20'h00001;
      step_pulse <= 1'b0;
    end
  end

  // Motor counts as stopped whenever no steps are asked for
  always_ff @(posedge clk_sys) begin
    standstill <= srst | ~run_en;
  end
endmodule : mcp_indexer_model

`default_nettype wire

// ==== dv/motor_current_powerdown_ctrl_tb.sv ====
// Purpose: Self-checking bench for the current power-down controller
// Assumes: Unit counts shortened to 4 and 8 clocks
// Notes: Register mirror and ramp queues give the expected register values and ramp steps

`timescale 1ns/1ps
`default_nettype none

module motor_current_powerdown_ctrl_tb;
  import mcp_pkg::*;
  localparam int RU = 4;
  localparam int HU = 8;
  logic clk_sys, srst, reg_we, reg_re, motion_req, pwm_voltage_mode, freewheel_sel, run_en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_reg, rd;
  logic [19:0] velocity_threshold, period;
  logic [4:0] current_scale_reg;
  logic step_pulse, standstill, run_current_reached_reg, freewheel_reg;
  logic coil_short_reg, below_threshold;
  logic [31:0] m_run = 32'h04011f08;
  logic [31:0] m_wait = 32'h0000000a;
  // Motor is stopped out of reset, so the interval already reads saturated
  logic [31:0] m_intv = 32'h000fffff;
  logic [7:0] addr_tab [4] = '{MCP_RUN_HOLD_IDX, MCP_PD_WAIT_IDX, MCP_INTERVAL_IDX, 8'h7f};
  int per_tab [5] = '{100, 165, 175, 165, 4};
  logic below_tab [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 32'h787e1eb7;
  int run_lvl, up_dly, dn_dly, first;

  mcp_ctrl #(.RUN_UNIT_CYC(RU), .HOLD_UNIT_CYC(HU)) dut (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_we(reg_we),
    .reg_wdata(reg_wdata), .reg_re(reg_re), .reg_rdata_reg(reg_rdata_reg),
    .motion_req(motion_req), .standstill(standstill), .step_pulse(step_pulse),
    .pwm_voltage_mode(pwm_voltage_mode), .freewheel_sel(freewheel_sel),
    .velocity_threshold(velocity_threshold), .current_scale_reg(current_scale_reg),
    .run_current_reached_reg(run_current_reached_reg), .freewheel_reg(freewheel_reg),
    .coil_short_reg(coil_short_reg), .below_threshold(below_threshold));

  mcp_indexer_model u_idx (
    .clk_sys(clk_sys), .srst(srst), .run_en(run_en), .period(period),
    .step_pulse(step_pulse), .standstill(standstill));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Mirror keeps only the implemented field bits
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
    if (a == MCP_RUN_HOLD_IDX) m_run = d & 32'h0f0f1f1f;
    if (a == MCP_PD_WAIT_IDX) m_wait = d & 32'h000000ff;
  endtask : wr

  task automatic rdreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata_reg;
  endtask : rdreg

  function automatic logic [31:0] expv(input logic [7:0] a);
    case (a)
      MCP_RUN_HOLD_IDX: expv = m_run;
      MCP_PD_WAIT_IDX: expv = m_wait;
      MCP_INTERVAL_IDX: expv = m_intv;
      default: expv = 32'h00000000;
    endcase
  endfunction : expv

  // Expected steps queued; a zero gap means one jump to the target
  task automatic ramp(input int from, input int to, input int gap, output int first);
    int q[$];
    int t;
    int last;
    int v;
    logic [4:0] prev;
    v = from;
    while (v != to) begin
      v = (to > v) ? v + 1 : v - 1;
      if (gap != 0 || v == to) q.push_back(v);
    end
    prev = current_scale_reg;
    last = -1;
    first = -1;
    t = 0;
    while (q.size() > 0 && t < 5000) begin
      @(posedge clk_sys);
      #1;
      t++;
      if (current_scale_reg !== prev) begin
        chk(current_scale_reg, q.pop_front());
        if (last >= 0) chk(t - last, gap);
        if (last < 0) first = t;
        last = t;
        prev = current_scale_reg;
      end
    end
    chk(q.size(), 0);
  endtask : ramp

  task report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Whole run needs at most about 8k cycles
  initial begin
    #900000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_we = 1'b0;
    reg_re = 1'b0;
    motion_req = 1'b0;
    pwm_voltage_mode = 1'b0;
    freewheel_sel = 1'b0;
    run_en = 1'b0;
    period = 20'd100;
    velocity_threshold = 20'd0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(current_scale_reg, 5'h08);
    chk(run_current_reached_reg, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rdreg(addr_tab[i], rd);
      chk(rd, expv(addr_tab[i]));
    end
    // Read-only interval ignores writes; wait count keeps only its low byte, giving 2
    wr(MCP_INTERVAL_IDX, 32'hffffffff);
    wr(MCP_PD_WAIT_IDX, 32'hffffff02);
    rdreg(MCP_INTERVAL_IDX, rd);
    chk(rd, expv(MCP_INTERVAL_IDX));
    rdreg(MCP_PD_WAIT_IDX, rd);
    chk(rd, expv(MCP_PD_WAIT_IDX));
    // Pass 0 is instant both ways, later passes use random delays
    for (int k = 0; k < 4; k++) begin
      up_dly = (k == 0) ? 0 : 1 + {$random(seed)} % 15;
      dn_dly = (k == 0) ? 0 : 1 + {$random(seed)} % 3;
      run_lvl = 16 + {$random(seed)} % 16;
      wr(MCP_RUN_HOLD_IDX, (up_dly << 24) | (dn_dly << 16) | (run_lvl << 8) | 8);
      rdreg(MCP_RUN_HOLD_IDX, rd);
      chk(rd, expv(MCP_RUN_HOLD_IDX));
      motion_req <= 1'b1;
      ramp(8, run_lvl, up_dly * RU, first);
      chk(first >= up_dly * RU && first <= up_dly * RU + 3, 1'b1);
      @(posedge clk_sys);
      #1;
      chk(run_current_reached_reg, 1'b1);
      chk(current_scale_reg, run_lvl);
      motion_req <= 1'b0;
      ramp(run_lvl, 8, dn_dly * HU, first);
      chk(first >= (2 + dn_dly) * HU && first <= (2 + dn_dly) * HU + 4, 1'b1);
    end
    // Step spacing across the hysteresis band around 160
    velocity_threshold <= 20'd160;
    for (int i = 0; i < 5; i++) begin
      period <= 20'(per_tab[i]);
      run_en <= 1'b1;
      repeat (per_tab[i] * 3 + 5) @(posedge clk_sys);
      m_intv = per_tab[i];
      rdreg(MCP_INTERVAL_IDX, rd);
      chk(rd, expv(MCP_INTERVAL_IDX));
      chk(below_threshold, below_tab[i]);
    end
    run_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    m_intv = 32'h000fffff;
    rdreg(MCP_INTERVAL_IDX, rd);
    chk(rd, expv(MCP_INTERVAL_IDX));
    // Standstill lost mid-wait restarts the whole power-down wait
    wr(MCP_RUN_HOLD_IDX, 32'h00001f08);
    motion_req <= 1'b1;
    ramp(8, 31, 0, first);
    motion_req <= 1'b0;
    repeat (10) @(posedge clk_sys);
    run_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    run_en <= 1'b0;
    ramp(31, 8, 0, first);
    chk(first >= 2 * HU && first <= 2 * HU + 4, 1'b1);
    // Zero standstill level in voltage mode selects the passive standstill
    wr(MCP_RUN_HOLD_IDX, 32'h00001f00);
    pwm_voltage_mode <= 1'b1;
    freewheel_sel <= 1'b1;
    repeat (30) @(posedge clk_sys);
    #1;
    chk(current_scale_reg, 5'h00);
    chk({freewheel_reg, coil_short_reg}, 2'b10);
    freewheel_sel <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({freewheel_reg, coil_short_reg}, 2'b01);
    pwm_voltage_mode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({freewheel_reg, coil_short_reg}, 2'b00);
    report_and_stop();
  end
endmodule : motor_current_powerdown_ctrl_tb

`default_nettype wire
